// *** logic/mlcb_top.sv ***
// Monitor and front-panel LED configuration bank with APB slave
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module mlcb_top
  import mlcb_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Board and chipset pins
  input wire logic SOFT_OFF_STATE_IN_N,
  input wire logic SUSPEND_RAM_STATE_IN_N,
  input wire logic RESUME_RESET_N,
  input wire logic POWER_GOOD,
  input wire logic HOST_BUS_RESET_N,
  input wire logic SYSTEM_FAN_TACH_IN,
  input wire logic PROCESSOR_FAN_TACH_IN,
  input wire logic BUS_CLOCK_IN,
  input wire logic BUS_DATA_IN,
  // Configuration towards the monitor
  output logic MONITOR_ACTIVE,
  output logic [11:0] MONITOR_BASE,
  output logic [11:0] SIDEBAND_BASE,
  output logic [3:0] MONITOR_IRQ,
  output logic MGMT_INTERRUPT_EN,
  output logic [7:0] SYSTEM_FAN_DUTY,
  output logic [7:0] PROCESSOR_FAN_DUTY,
  // Filtered inputs
  output logic [3:0] FILTERED_IN,
  // LEDs
  output logic MESSAGE_LED,
  output logic GREEN_LED_OUT,
  output logic GREEN_LED_OE,
  output logic YELLOW_LED_OUT,
  output logic YELLOW_LED_OE
);
  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [PIN_N-1:0] pin_raw; // Raw pins
  logic [PIN_N-1:0] s1_q, s2_q, s3_q; // Three stages
  logic [PIN_N-1:0] clean_q; // Agreed level
  assign pin_raw = {BUS_DATA_IN, BUS_CLOCK_IN, PROCESSOR_FAN_TACH_IN,
                    SYSTEM_FAN_TACH_IN, HOST_BUS_RESET_N, POWER_GOOD,
                    RESUME_RESET_N, SOFT_OFF_STATE_IN_N & SUSPEND_RAM_STATE_IN_N};
  // Three-stage chain, change taken once stages two and three agree
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s1_q <= PIN_RST;
      s2_q <= PIN_RST;
      s3_q <= PIN_RST;
      clean_q <= PIN_RST;
    end
    else if (CE)
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= (s2_q & s3_q) | (clean_q & (s2_q ^ s3_q));
    end
  end
  logic awake; // Both sleep inputs high
  logic resume_rst; // Resume reset asserted
  logic pg_low; // Power-good absent
  logic host_rst; // Host bus reset asserted
  assign awake = clean_q[0];
  assign resume_rst = ~clean_q[1];
  assign pg_low = ~clean_q[2];
  assign host_rst = ~clean_q[3];
  // Separate soft-off flag for deep-S5 entry
  logic off_s1_q, off_s2_q, off_s3_q, off_q;
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      off_s1_q <= 1'b1;
      off_s2_q <= 1'b1;
      off_s3_q <= 1'b1;
      off_q <= 1'b1;
    end
    else if (CE)
    begin
      off_s1_q <= SOFT_OFF_STATE_IN_N;
      off_s2_q <= off_s1_q;
      off_s3_q <= off_s2_q;
      if (off_s2_q == off_s3_q)
        off_q <= off_s3_q;
    end
  end
  // ********************************************************
  // Registers
  // ********************************************************
  logic act_q; // Monitor active
  logic [3:0] mb_hi_q, sb_hi_q; // Base high nibbles
  logic [7:0] mb_lo_q, sb_lo_q; // Base low bytes
  logic [3:0] irq_q; // Interrupt line
  logic [7:0] sys_duty_q, cpu_duty_q; // Fan duties
  logic [1:0] tach_db_q; // Tach debounce enables
  logic mgmt_q; // Management interrupt enable
  logic [2:0] msg_q; // Message LED code
  logic [1:0] bus_db_q; // Bus debounce enables
  logic [7:0] deep_blink_q; // Deep-S5 codes
  logic auto_q; // Automatic control
  logic [7:0] grn_q, ylw_q; // LED controls, bit 7 unused here
  logic [1:0] force_q; // Deep-S5 force high
  logic deep_en_q; // Deep-S5 enable
  logic [9:0] idx; // Word index
  logic wr; // Write taken this edge
  logic [7:0] wd; // Write byte
  logic sleep_q; // Asleep last cycle
  logic entry; // Sleep entry pulse
  assign idx = PADDR[11:2];
  assign wr = PSEL & PENABLE & PWRITE & PREADY & ~PSLVERR & CE;
  assign wd = PWDATA[7:0];
  assign entry = ~awake & ~sleep_q;
  // Host bus reset well
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      act_q <= 1'b0;
      mb_hi_q <= 4'h0;
      mb_lo_q <= 8'h00;
      sb_hi_q <= 4'h0;
      sb_lo_q <= 8'h00;
      irq_q <= 4'h0;
      tach_db_q <= 2'h0;
      mgmt_q <= 1'b0;
    end
    else if (CE)
    begin
      if (host_rst)
      begin
        act_q <= 1'b0;
        mb_hi_q <= 4'h0;
        mb_lo_q <= 8'h00;
        sb_hi_q <= 4'h0;
        sb_lo_q <= 8'h00;
        irq_q <= 4'h0;
        tach_db_q <= 2'h0;
        mgmt_q <= 1'b0;
      end
      else if (wr)
      begin
        unique case (idx)
          IDX_ACTIVATE: act_q <= wd[0];
          IDX_MON_BASE_HI: mb_hi_q <= wd[3:0];
          IDX_MON_BASE_LO: mb_lo_q <= {wd[7:1], 1'b0};
          IDX_SB_BASE_HI: sb_hi_q <= wd[3:0];
          IDX_SB_BASE_LO: sb_lo_q <= {wd[7:1], 1'b0};
          IDX_IRQ_SEL: irq_q <= wd[3:0];
          IDX_TACH_DB: tach_db_q <= wd[2:1];
          IDX_MGMT_IRQ: mgmt_q <= wd[7];
          default: ;
        endcase
      end
    end
  end
  // Resume reset well, message bits also follow power-good
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sys_duty_q <= DUTY_RST;
      cpu_duty_q <= DUTY_RST;
      msg_q <= 3'h0;
      bus_db_q <= 2'h0;
      auto_q <= 1'b1;
    end
    else if (CE)
    begin
      if (resume_rst)
      begin
        sys_duty_q <= DUTY_RST;
        cpu_duty_q <= DUTY_RST;
        msg_q <= 3'h0;
        bus_db_q <= 2'h0;
        auto_q <= 1'b1;
      end
      else
      begin
        if (wr && idx == IDX_SYS_DUTY)
          sys_duty_q <= wd;
        if (wr && idx == IDX_CPU_DUTY)
          cpu_duty_q <= wd;
        if (pg_low)
          msg_q <= 3'h0;
        else if (wr && idx == IDX_MSG_BUS)
          msg_q <= wd[7:MSG_LSB];
        if (wr && idx == IDX_MSG_BUS)
          bus_db_q <= wd[1:0];
        if (wr && idx == IDX_GREEN)
          auto_q <= wd[AUTO_BIT];
      end
    end
  end
  // Battery well; sleep entry clear wins over a write
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      deep_blink_q <= 8'h00;
      grn_q <= GREEN_RST;
      ylw_q <= YELLOW_RST;
      force_q <= 2'h0;
      deep_en_q <= 1'b0;
      sleep_q <= 1'b0;
    end
    else if (CE)
    begin
      sleep_q <= ~awake;
      if (wr && idx == IDX_DEEP_BLINK)
        deep_blink_q <= wd;
      if (wr && idx == IDX_DEEP_FORCE)
        force_q <= wd[FORCE_Y_BIT:FORCE_G_BIT];
      if (wr && idx == IDX_DEEP_CFG)
        deep_en_q <= wd[0];
      if (wr && idx == IDX_GREEN)
        grn_q <= {1'b0, wd[6:5], 1'b0, wd[3:0]};
      if (wr && idx == IDX_YELLOW)
        ylw_q <= {1'b0, wd[6:5], 1'b0, wd[3:0]};
      if (entry && !grn_q[KEEP_BIT])
        grn_q[3:0] <= CODE_HIZ;
      if (entry && !ylw_q[KEEP_BIT])
        ylw_q[3:0] <= CODE_HIZ;
    end
  end
  // ********************************************************
  // APB answer, no wait state, unmapped index errors
  // ********************************************************
  logic [7:0] rd; // Read byte
  logic hit; // Mapped index
  always_comb
  begin
    rd = 8'h00;
    hit = 1'b1;
    unique case (idx)
      IDX_ACTIVATE: rd = {7'h00, act_q};
      IDX_MON_BASE_HI: rd = {4'h0, mb_hi_q};
      IDX_MON_BASE_LO: rd = mb_lo_q;
      IDX_SB_BASE_HI: rd = {4'h0, sb_hi_q};
      IDX_SB_BASE_LO: rd = sb_lo_q;
      IDX_IRQ_SEL: rd = {4'h0, irq_q};
      IDX_DEEP_CFG: rd = {7'h00, deep_en_q};
      IDX_SYS_DUTY: rd = sys_duty_q;
      IDX_CPU_DUTY: rd = cpu_duty_q;
      IDX_TACH_DB: rd = {5'h00, tach_db_q, 1'b0};
      IDX_MGMT_IRQ: rd = {mgmt_q, 7'h00};
      IDX_MSG_BUS: rd = {msg_q, 3'h0, bus_db_q};
      IDX_DEEP_BLINK: rd = deep_blink_q;
      IDX_GREEN: rd = {auto_q, grn_q[6:0]};
      IDX_YELLOW: rd = ylw_q;
      IDX_DEEP_FORCE: rd = {2'h0, force_q, 4'h0};
      default: hit = 1'b0;
    endcase
  end
  // Ready raised in the access phase for one cycle
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end
    else if (CE)
    begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~hit;
      PRDATA <= (PSEL & ~PENABLE & ~PWRITE) ? {24'h000000, rd} : 32'h0000_0000;
    end
  end
  // ********************************************************
  // Debouncers for tach and bus inputs
  // ********************************************************
  logic [3:0] db_en; // Per-input enable
  assign db_en = {bus_db_q[0], bus_db_q[1], tach_db_q[1], tach_db_q[0]};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_db
      localparam int LIM = (gi < 2) ? TACH_DB_CYC : SMB_DB_CYC;
      logic [7:0] cnt_q; // Stable-difference count
      logic filt_q; // Debounced level
      // Follow raw level once it differed for LIM cycles
      always_ff @(posedge MCLK or negedge RESET_N)
      begin
        if (!RESET_N)
        begin
          cnt_q <= 8'h00;
          filt_q <= 1'b1;
          FILTERED_IN[gi] <= 1'b1;
        end
        else if (CE)
        begin
          if (clean_q[gi+4] == filt_q)
            cnt_q <= 8'h00;
          else if (cnt_q == 8'(LIM - 1))
          begin
            cnt_q <= 8'h00;
            filt_q <= clean_q[gi+4];
          end
          else
            cnt_q <= cnt_q + 8'h01;
          // Bypass when disabled
          FILTERED_IN[gi] <= db_en[gi] ? filt_q : clean_q[gi+4];
        end
      end
    end
  endgenerate
  // ********************************************************
  // Blink time base and fading ramp
  // ********************************************************
  logic [21:0] pre_q; // Sixteenth-second prescaler
  logic [7:0] tick_q; // Bit k toggles every 2^k ticks
  logic [6:0] pwm_q; // Fading carrier
  logic [6:0] lvl; // Fading brightness
  logic fade_lit; // Fading pulse
  // Free-running counters, square waves at 50 percent
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pre_q <= 22'h000000;
      tick_q <= 8'h00;
      pwm_q <= 7'h00;
    end
    else if (CE)
    begin
      pwm_q <= pwm_q + 7'h01;
      if (pre_q == 22'(TICK_CYCLES - 1))
      begin
        pre_q <= 22'h000000;
        tick_q <= tick_q + 8'h01;
      end
      else
        pre_q <= pre_q + 22'h000001;
    end
  end
  assign lvl = tick_q[7] ? ~tick_q[6:0] : tick_q[6:0];
  assign fade_lit = pwm_q < lvl;
  // Code to {enable, active-low level}
  function automatic logic [1:0] led_pin(input logic [3:0] code);
    logic [1:0] r;
    r = 2'b10;
    if (code[3])
      r = {1'b1, ~fade_lit};
    else
      unique case (code[2:0])
        3'h0: r = 2'b00;
        3'h1: r = {1'b1, tick_q[7]};
        3'h2: r = {1'b1, tick_q[6]};
        3'h3: r = {1'b1, tick_q[5]};
        3'h4: r = {1'b1, tick_q[4]};
        3'h5: r = {1'b1, tick_q[3]};
        3'h6: r = {1'b1, tick_q[2]};
        3'h7: r = 2'b10;
      endcase
    return r;
  endfunction
  // ********************************************************
  // LED selection
  // ********************************************************
  logic deep; // Deep-S5 in effect
  logic [3:0] g_code, y_code; // Effective codes
  logic [1:0] g_pin, y_pin; // Enable and level
  assign deep = deep_en_q & ~off_q;
  always_comb
  begin
    g_code = grn_q[3:0];
    y_code = ylw_q[3:0];
    if (deep)
    begin
      g_code = deep_blink_q[3:0];
      y_code = deep_blink_q[7:4];
    end
    else if (auto_q)
    begin
      // Awake lights green, suspend blinks yellow, off is dark
      g_code = awake ? CODE_LOW : CODE_HIZ;
      y_code = (!awake && clean_q[0] == 1'b0 && off_q) ? CODE_1HZ : CODE_HIZ;
    end
  end
  // Process form so that tick and fading changes re-evaluate the pins
  always_comb
  begin
    g_pin = led_pin(g_code);
    y_pin = led_pin(y_code);
  end
  // Registered pins, polarity flips the level, force drives high
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      GREEN_LED_OUT <= 1'b1;
      GREEN_LED_OE <= 1'b0;
      YELLOW_LED_OUT <= 1'b1;
      YELLOW_LED_OE <= 1'b0;
      MESSAGE_LED <= 1'b1;
    end
    else if (CE)
    begin
      GREEN_LED_OE <= (deep & force_q[0]) | g_pin[1];
      GREEN_LED_OUT <= (deep & force_q[0]) | (g_pin[0] ^ grn_q[POL_BIT]);
      YELLOW_LED_OE <= (deep & force_q[1]) | y_pin[1];
      YELLOW_LED_OUT <= (deep & force_q[1]) | (y_pin[0] ^ ylw_q[POL_BIT]);
      unique case (msg_q)
        3'h1: MESSAGE_LED <= 1'b0;
        3'h2: MESSAGE_LED <= tick_q[1];
        3'h3: MESSAGE_LED <= tick_q[2];
        3'h4: MESSAGE_LED <= tick_q[3];
        3'h5: MESSAGE_LED <= tick_q[4];
        3'h7: MESSAGE_LED <= tick_q[6];
        default: MESSAGE_LED <= 1'b1;
      endcase
    end
  end
  // ********************************************************
  // Configuration outputs straight from registers
  // ********************************************************
  assign MONITOR_ACTIVE = act_q;
  assign MONITOR_BASE = {mb_hi_q, mb_lo_q};
  assign SIDEBAND_BASE = {sb_hi_q, sb_lo_q};
  assign MONITOR_IRQ = irq_q;
  assign MGMT_INTERRUPT_EN = mgmt_q;
  assign SYSTEM_FAN_DUTY = sys_duty_q;
  assign PROCESSOR_FAN_DUTY = cpu_duty_q;
  // ********************************************************
  // Assertions
  // ********************************************************
  a_activate_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
    wr && idx == IDX_ACTIVATE && !host_rst |=> MONITOR_ACTIVE == $past(PWDATA[0]))
    else $error("activate bit not stored");
  a_base_even: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !MONITOR_BASE[0] && !SIDEBAND_BASE[0])
    else $error("base address odd");
  a_irq_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
    wr && idx == IDX_IRQ_SEL && !host_rst |=> MONITOR_IRQ == $past(PWDATA[3:0]))
    else $error("irq select not stored");
  a_duty_resume: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && resume_rst |=> SYSTEM_FAN_DUTY == 8'h7F && PROCESSOR_FAN_DUTY == 8'h7F)
    else $error("duty not reset");
  a_auto_resume: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && resume_rst |=> auto_q)
    else $error("auto bit not set on resume");
  a_msg_pg: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && pg_low |=> msg_q == 3'h0)
    else $error("message code kept without power-good");
  a_msg_low: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && msg_q == 3'h1 |=> !MESSAGE_LED)
    else $error("message LED not low");
  a_sleep_clear: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && entry && !grn_q[KEEP_BIT] |=> grn_q[3:0] == 4'h0)
    else $error("green code kept on sleep");
  a_deep_force: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && deep && force_q[0] |=> GREEN_LED_OUT && GREEN_LED_OE)
    else $error("green not forced high");
  a_hiz_code: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && !deep && g_code == 4'h0 |=> !GREEN_LED_OE)
    else $error("green driven on high-Z code");
endmodule
`default_nettype wire

// *** inc/mlcb_pkg.sv ***
// Constants, offsets and reset values of the monitor and LED configuration bank
package mlcb_pkg;
  // ********************************************************
  // Register indices, byte address is four times the index
  // ********************************************************
  localparam logic [9:0] IDX_ACTIVATE = 10'h030;
  localparam logic [9:0] IDX_MON_BASE_HI = 10'h060;
  localparam logic [9:0] IDX_MON_BASE_LO = 10'h061;
  localparam logic [9:0] IDX_SB_BASE_HI = 10'h062;
  localparam logic [9:0] IDX_SB_BASE_LO = 10'h063;
  localparam logic [9:0] IDX_IRQ_SEL = 10'h070;
  localparam logic [9:0] IDX_DEEP_CFG = 10'h080;
  localparam logic [9:0] IDX_SYS_DUTY = 10'h0E0;
  localparam logic [9:0] IDX_CPU_DUTY = 10'h0E1;
  localparam logic [9:0] IDX_TACH_DB = 10'h0F0;
  localparam logic [9:0] IDX_MGMT_IRQ = 10'h0F1;
  localparam logic [9:0] IDX_MSG_BUS = 10'h0F5;
  localparam logic [9:0] IDX_DEEP_BLINK = 10'h0F6;
  localparam logic [9:0] IDX_GREEN = 10'h0F7;
  localparam logic [9:0] IDX_YELLOW = 10'h0F8;
  localparam logic [9:0] IDX_DEEP_FORCE = 10'h0F9;
  // ********************************************************
  // Reset values and field positions
  // ********************************************************
  localparam logic [7:0] DUTY_RST = 8'h7F;
  localparam logic [7:0] GREEN_RST = 8'h87;
  localparam logic [7:0] YELLOW_RST = 8'h47;
  localparam int AUTO_BIT = 7;
  localparam int KEEP_BIT = 6;
  localparam int POL_BIT = 5;
  localparam int MSG_LSB = 5;
  localparam int FORCE_Y_BIT = 5;
  localparam int FORCE_G_BIT = 4;
  // LED codes used by automatic control
  localparam logic [3:0] CODE_HIZ = 4'h0;
  localparam logic [3:0] CODE_LOW = 4'h7;
  localparam logic [3:0] CODE_1HZ = 4'h5;
  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_NS = 20;
  localparam int SMB_DB_NS = 160;
  localparam int SMB_DB_CYC = (SMB_DB_NS + CLK_NS - 1) / CLK_NS;
  localparam int TACH_DB_NS = 1000;
  localparam int TACH_DB_CYC = (TACH_DB_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_US = 62500;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  // Pin count and reset level of the synchroniser bank
  localparam int PIN_N = 8;
  localparam logic [7:0] PIN_RST = 8'hFF;
endpackage

// *** verif/mlcb_partner.sv ***
// Board side model: chipset sleep pins, fan tachometers, bus pins, LED pull-ups
`timescale 1ns/1ns
`default_nettype none
module mlcb_partner
(
  // Clock and sleep requests from the bench
  input wire logic clk,
  input wire logic go_s5,
  input wire logic go_s3,
  // Chipset sleep pins, low while asleep
  output logic soft_off_n,
  output logic suspend_n,
  // Fan tachometers and two-wire bus lines
  output logic sys_tach,
  output logic cpu_tach,
  output logic bus_clk,
  output logic bus_dat,
  // LED drivers and the board level of each LED line
  input wire logic g_out,
  input wire logic g_oe,
  input wire logic y_out,
  input wire logic y_oe,
  output logic g_pin,
  output logic y_pin
);
  logic [7:0] cnt_q = 8'h00; // Free running count for the pulse trains
  // Pull-ups hold an undriven LED line high
  assign g_pin = g_oe ? g_out : 1'b1;
  assign y_pin = y_oe ? y_out : 1'b1;
  // Soft-off also drops the suspend line
  assign soft_off_n = ~go_s5;
  assign suspend_n = ~(go_s3 | go_s5);
  // Pulse trains at unrelated rates
  assign sys_tach = cnt_q[5];
  assign cpu_tach = cnt_q[4] ^ cnt_q[6];
  assign bus_clk = cnt_q[2];
  assign bus_dat = cnt_q[3];
  always_ff @(posedge clk)
  begin
    cnt_q <= cnt_q + 8'h01;
  end
endmodule
`default_nettype wire

// *** verif/monitor_led_config_bank_bench.sv ***
// Self-checking bench for the monitor and LED configuration bank
`timescale 1ns/1ns
`default_nettype none
module monitor_led_config_bank_bench;
  import mlcb_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h00000000;
  logic rsm_n = 1'b1, pgood = 1'b1, hbr_n = 1'b1, go_s5 = 1'b0, go_s3 = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, g_out, g_oe, y_out, y_oe, g_pin, y_pin, message_led;
  logic s5_n, s3_n, st, ct, bc, bd;
  logic [11:0] mbase;
  logic [7:0] sduty;
  logic [11:0] sbase;
  logic [7:0] pduty;
  logic [3:0] irq, filt;
  logic act, mgmt;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  logic [31:0] rs = 32'h00005D10;
  // Register index, writable mask and reset value
  logic [9:0] rix [16] = '{10'h030, 10'h060, 10'h061, 10'h062, 10'h063, 10'h070,
    10'h0E0, 10'h0E1, 10'h0F0, 10'h0F1, 10'h0F5, 10'h0F6, 10'h0F7, 10'h0F8, 10'h0F9, 10'h080};
  logic [7:0] rmsk [16] = '{8'h01, 8'h0F, 8'hFE, 8'h0F, 8'hFE, 8'h0F, 8'hFF, 8'hFF,
    8'h06, 8'h80, 8'hE3, 8'hFF, 8'hEF, 8'h6F, 8'h30, 8'h01};
  logic [7:0] rrst [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h7F,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h87, 8'h47, 8'h00, 8'h00};
  logic [2:0] mcode [3] = '{3'h0, 3'h1, 3'h6};
  logic mexp [3] = '{1'b1, 1'b0, 1'b1};
  // ****************************************
  // Design and board model
  // ****************************************
  mlcb_top #(.TICK_CYCLES(4)) dut (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SOFT_OFF_STATE_IN_N(s5_n), .SUSPEND_RAM_STATE_IN_N(s3_n),
    .RESUME_RESET_N(rsm_n), .POWER_GOOD(pgood), .HOST_BUS_RESET_N(hbr_n),
    .SYSTEM_FAN_TACH_IN(st), .PROCESSOR_FAN_TACH_IN(ct), .BUS_CLOCK_IN(bc),
    .BUS_DATA_IN(bd), .MONITOR_ACTIVE(act), .MONITOR_BASE(mbase), .SIDEBAND_BASE(sbase),
    .MONITOR_IRQ(irq), .MGMT_INTERRUPT_EN(mgmt), .SYSTEM_FAN_DUTY(sduty),
    .PROCESSOR_FAN_DUTY(pduty), .FILTERED_IN(filt), .MESSAGE_LED(message_led),
    .GREEN_LED_OUT(g_out), .GREEN_LED_OE(g_oe), .YELLOW_LED_OUT(y_out),
    .YELLOW_LED_OE(y_oe));
  mlcb_partner board (.clk(mclk), .go_s5(go_s5), .go_s3(go_s3), .soft_off_n(s5_n),
    .suspend_n(s3_n), .sys_tach(st), .cpu_tach(ct), .bus_clk(bc), .bus_dat(bd),
    .g_out(g_out), .g_oe(g_oe), .y_out(y_out), .y_oe(y_oe), .g_pin(g_pin),
    .y_pin(y_pin));
  // ****************************************
  // Clock, hang guard and helpers
  // ****************************************
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  // Cut a hung run short
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  // Seeded xorshift source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Compare and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is seen high
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] wd,
    output logic [7:0] rd, output logic er);
    @(posedge mclk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= {ix, 2'b00};
    pwd <= {24'h000000, wd};
    @(posedge mclk);
    pen <= 1'b1;
    // Access phase lasts until ready is seen high at a rising edge
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    logic [7:0] rd;
    logic er;
    apb(1'b1, ix, d, rd, er);
  endtask
  // Read and check value, error flag low
  task automatic rdc(input logic [9:0] ix, input logic [7:0] exp);
    logic [7:0] rd;
    logic er;
    apb(1'b0, ix, 8'h00, rd, er);
    chk({3'h0, er, rd}, {4'h0, exp});
  endtask
  // Wait whole cycles, ending where outputs are settled
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [7:0] d, rd;
    logic er, pv;
    logic [3:0] pf;
    int tg;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    wt(6);
    for (int i = 0; i < 16; i++)
      rdc(rix[i], rrst[i]);
    // Random contents, reserved bits dropped
    for (int k = 0; k < 32; k++)
    begin
      rs = xs(rs);
      d = rs[7:0];
      wr(rix[k % 16], d);
      rdc(rix[k % 16], d & rmsk[k % 16]);
    end
    wr(10'h060, 8'hFA);
    wr(10'h061, 8'hBD);
    wr(10'h0E0, 8'h3C);
    wr(10'h062, 8'hF3);
    wr(10'h063, 8'h45);
    wr(10'h070, 8'h5A);
    wr(10'h0E1, 8'h81);
    wr(10'h030, 8'h01);
    wr(10'h0F1, 8'hFF);
    wt(2);
    chk(mbase, 12'hABC);
    chk({4'h0, sduty}, 12'h03C);
    chk(sbase, 12'h344);
    chk({irq, pduty}, 12'hA81);
    chk({10'h000, act, mgmt}, 12'h003);
    // Unmapped place refuses and reads zero
    apb(1'b1, 10'h3FF, 8'h55, rd, er);
    apb(1'b0, 10'h3FF, 8'h00, rd, er);
    chk({3'h0, er, rd}, 12'h100);
    // Filters: bypass passes every edge, debouncers swallow short runs
    for (int m = 0; m < 2; m++)
    begin
      wr(10'h0F0, m ? 8'h06 : 8'h00);
      wr(10'h0F5, m ? 8'h03 : 8'h00);
      wt(60);
      tg = 0;
      pf = filt;
      repeat (128)
      begin
        @(negedge mclk);
        tg += int'(filt[0] !== pf[0]) + 100 * int'(filt[2] !== pf[2]);
        pf = filt;
      end
      chk(tg[11:0], m ? 12'h000 : 12'hC84);
    end
    foreach (mcode[i])
    begin
      wr(10'h0F5, {mcode[i], 5'h00});
      wt(3);
      chk({11'h000, message_led}, {11'h000, mexp[i]});
    end
    // Message LED at 4 Hz: eight-cycle half period with four-cycle ticks
    wr(10'h0F5, 8'h40);
    wt(4);
    tg = 0;
    pv = message_led;
    repeat (64)
    begin
      @(negedge mclk);
      tg += int'(message_led !== pv);
      pv = message_led;
    end
    chk(tg[11:0], 12'h008);
    // Green steady low, inverted, then released
    wr(10'h0F7, 8'h47);
    wt(3);
    chk({10'h000, g_oe, g_pin}, 12'h002);
    wr(10'h0F7, 8'h67);
    wt(3);
    chk({10'h000, g_oe, g_pin}, 12'h003);
    wr(10'h0F7, 8'h40);
    wt(3);
    chk({10'h000, g_oe, g_pin}, 12'h001);
    // Fastest blink: 16 cycle half period with four-cycle ticks
    wr(10'h0F7, 8'h46);
    wt(4);
    tg = 0;
    pv = g_pin;
    repeat (160)
    begin
      @(negedge mclk);
      tg += int'(g_pin !== pv);
      pv = g_pin;
    end
    chk({11'h000, tg >= 9 && tg <= 11}, 12'h001);
    // Sleep entry clears only the code without keep
    wr(10'h0F8, 8'h05);
    @(posedge mclk);
    go_s3 <= 1'b1;
    wt(10);
    rdc(10'h0F8, 8'h00);
    rdc(10'h0F7, 8'h46);
    wr(10'h0F7, 8'hC0);
    go_s3 <= 1'b0;
    wt(8);
    chk({8'h00, g_oe, g_pin, y_oe, y_pin}, 12'h009);
    @(posedge mclk);
    go_s3 <= 1'b1;
    wt(8);
    chk({10'h000, g_oe, y_oe}, 12'h001);
    // Soft-off without, then with, the deep state enabled
    wr(10'h0F9, 8'h10);
    wr(10'h0F6, 8'h70);
    wr(10'h080, 8'h00);
    go_s5 <= 1'b1;
    wt(8);
    chk({10'h000, g_oe, y_oe}, 12'h000);
    wr(10'h080, 8'h01);
    wt(8);
    chk({8'h00, g_oe, g_pin, y_oe, y_pin}, 12'h00E);
    @(posedge mclk);
    go_s5 <= 1'b0;
    go_s3 <= 1'b0;
    // Power-good clears only the message field
    wr(10'h0F7, 8'h47);
    wr(10'h0F5, 8'hE3);
    wr(10'h030, 8'h01);
    pgood <= 1'b0;
    wt(8);
    @(posedge mclk);
    pgood <= 1'b1;
    rdc(10'h0F5, 8'h03);
    @(posedge mclk);
    rsm_n <= 1'b0;
    hbr_n <= 1'b0;
    wt(8);
    @(posedge mclk);
    rsm_n <= 1'b1;
    hbr_n <= 1'b1;
    wt(6);
    rdc(10'h0F7, 8'hC7);
    rdc(10'h0F5, 8'h00);
    rdc(10'h0E0, 8'h7F);
    rdc(10'h030, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
